/* verification/sspf_assertions.sv */
// Concurrent checks on the serial slave port pins
`timescale 1ns/10ps
module sspf_assertions (
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       SCK,
    input wire logic       SLAVE_SELECT_IN,
    input wire logic       MISO_OE,
    input wire logic       PORT_ENABLE_BIT,
    input wire logic       MASTER_ENABLE_BIT,
    input wire logic       SELECT_MODE_BIT_HI,
    input wire logic       SELECT_MODE_BIT_LO,
    input wire logic       INT_ENABLE,
    input wire logic       DATA_RD,
    input wire logic [7:0] DATA_RDATA,
    input wire logic       CLR_TRANSFER_DONE,
    input wire logic       CLR_WRITE_COLLISION,
    input wire logic       CLR_MODE_FAULT,
    input wire logic       CLR_RECEIVE_OVERRUN,
    input wire logic       TRANSFER_DONE_FLAG,
    input wire logic       WRITE_COLLISION_FLAG,
    input wire logic       MODE_FAULT_FLAG,
    input wire logic       RECEIVE_OVERRUN_FLAG,
    input wire logic       FORCE_DISABLE,
    input wire logic       IRQ
);
    logic any_flag;
    logic mode_4w;
    assign any_flag = TRANSFER_DONE_FLAG | WRITE_COLLISION_FLAG | MODE_FAULT_FLAG
                    | RECEIVE_OVERRUN_FLAG;
    assign mode_4w = !SELECT_MODE_BIT_HI && SELECT_MODE_BIT_LO;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////////////////////
    a_irq_raised: assert property (INT_ENABLE && any_flag |=> IRQ)
        else $error("request missing while a flag is set");
    a_irq_masked: assert property (!INT_ENABLE |=> !IRQ)
        else $error("request raised while masked");
    a_done_sticky: assert property (
        TRANSFER_DONE_FLAG && !CLR_TRANSFER_DONE |=> TRANSFER_DONE_FLAG)
        else $error("done flag dropped without clear");
    a_write_collision_flag_sticky: assert property (
        WRITE_COLLISION_FLAG && !CLR_WRITE_COLLISION |=> WRITE_COLLISION_FLAG)
        else $error("collision flag dropped without clear");
    a_mode_fault_flag_sticky: assert property (
        MODE_FAULT_FLAG && !CLR_MODE_FAULT |=> MODE_FAULT_FLAG)
        else $error("fault flag dropped without clear");
    a_ovr_sticky: assert property (
        RECEIVE_OVERRUN_FLAG && !CLR_RECEIVE_OVERRUN |=> RECEIVE_OVERRUN_FLAG)
        else $error("overrun flag dropped without clear");
    a_oe_idle: assert property (
        (mode_4w && !MASTER_ENABLE_BIT && SLAVE_SELECT_IN) [*4] |-> !MISO_OE)
        else $error("output driven while deselected");
    a_no_self_start: assert property (
        $stable(SCK) [*8] |=> !$rose(TRANSFER_DONE_FLAG))
        else $error("byte completed without clock edges");
    a_mode_fault_flag_sets: assert property (
        (MASTER_ENABLE_BIT && PORT_ENABLE_BIT && mode_4w && !SLAVE_SELECT_IN) [*4]
        |-> ##[0:4] (MODE_FAULT_FLAG && FORCE_DISABLE))
        else $error("fault not raised");
    a_rdata_kept: assert property (
        $rose(RECEIVE_OVERRUN_FLAG) && !DATA_RD |-> $stable(DATA_RDATA))
        else $error("buffer changed on overrun");
    c_done: cover property ($rose(TRANSFER_DONE_FLAG));
    c_write_collision_flag: cover property ($rose(WRITE_COLLISION_FLAG));
    c_ovr: cover property ($rose(RECEIVE_OVERRUN_FLAG));
    c_mode_fault_flag: cover property ($rose(MODE_FAULT_FLAG));
endmodule : sspf_assertions
bind sspf_top sspf_assertions sspf_assertions_inst (.*);

/* verification/sspf_master_model.sv */
// Behavioural serial master on the far side of the port
`timescale 1ns/10ps
module sspf_master_model (
    output logic      sck,
    output logic      mosi,
    output logic      ss_n,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic cpol;
    initial begin
        cpol = 1'b0;
        sck = 1'b0;
        mosi = 1'b1;
        ss_n = 1'b1;
    end
    // Shift n bits MSB first, 200 ns per bit
    task automatic xfer(input logic [7:0] tx, input int n, input logic sel,
                        output logic [7:0] rx);
        rx = 8'h00;
        #3;
        if (sel) ss_n = 1'b0;
        #200;
        for (int i = 7; i > 7 - n; i--) begin
            mosi = tx[i];
            #100;
            rx = {rx[6:0], miso_oe ? miso : 1'bx};
            sck = ~cpol;
            #100;
            sck = cpol;
        end
        #100;
        mosi = ~mosi;
        ss_n = 1'b1;
    endtask : xfer
    // Idle clock level; only changed between frames
    task automatic set_pol(input logic p);
        cpol = p;
        sck = p;
    endtask : set_pol
endmodule : sspf_master_model

/* verification/sspf_top_bench.sv */
// Self-checking bench for the serial slave port
`timescale 1ns/10ps
module sspf_top_bench;
    logic       CLK, SRST, CE, SCK, MOSI, SLAVE_SELECT_IN, MISO, MISO_OE, IRQ;
    logic       PORT_ENABLE_BIT, MASTER_ENABLE_BIT, SELECT_MODE_BIT_HI, SELECT_MODE_BIT_LO;
    logic       CLK_PHASE, CLK_POLARITY, INT_ENABLE, DATA_WR, DATA_RD, FORCE_DISABLE;
    logic       CLR_TRANSFER_DONE, CLR_WRITE_COLLISION, CLR_MODE_FAULT, CLR_RECEIVE_OVERRUN;
    logic       TRANSFER_DONE_FLAG, WRITE_COLLISION_FLAG, MODE_FAULT_FLAG, RECEIVE_OVERRUN_FLAG;
    logic [7:0] DATA_WDATA, DATA_RDATA, rx;
    int         fails = 0, check_count = 0, cyc = 0;
    sspf_top sspf_top_inst (.*);
    sspf_master_model sspf_master_model_inst (.sck(SCK), .mosi(MOSI), .ss_n(SLAVE_SELECT_IN),
                                              .miso(MISO), .miso_oe(MISO_OE));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask : cmp_bit
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick
    task automatic wr(input logic [7:0] d);
        @(posedge CLK);
        DATA_WR <= 1'b1;
        DATA_WDATA <= d;
        @(posedge CLK);
        DATA_WR <= 1'b0;
    endtask : wr
    task automatic rd_clr;
        @(posedge CLK);
        {DATA_RD, CLR_TRANSFER_DONE, CLR_WRITE_COLLISION} <= 3'h7;
        {CLR_MODE_FAULT, CLR_RECEIVE_OVERRUN} <= 2'h3;
        @(posedge CLK);
        {DATA_RD, CLR_TRANSFER_DONE, CLR_WRITE_COLLISION} <= 3'h0;
        {CLR_MODE_FAULT, CLR_RECEIVE_OVERRUN} <= 2'h0;
        tick(2);
    endtask : rd_clr
    task automatic cfg(input logic [1:0] md, input logic en, input logic ms);
        @(posedge CLK);
        {SELECT_MODE_BIT_HI, SELECT_MODE_BIT_LO} <= md;
        {PORT_ENABLE_BIT, MASTER_ENABLE_BIT} <= {en, ms};
        tick(6);
    endtask : cfg
    task automatic xfern(input logic [7:0] tx, input int n, input logic sel);
        sspf_master_model_inst.xfer(tx, n, sel, rx);
        for (int i = 0; i < 40 && TRANSFER_DONE_FLAG !== 1'b1; i++) @(posedge CLK);
        tick(4);
        cmp_bit(TRANSFER_DONE_FLAG, 1'b1);
    endtask : xfern
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_basic;
        wr(8'hA5);
        xfern(8'h3C, 8, 1'b1);
        cmp_byte(rx, 8'hA5);
        cmp_byte(DATA_RDATA, 8'h3C);
        cmp_bit(IRQ, 1'b1);
        INT_ENABLE <= 1'b0;
        tick(2);
        cmp_bit(IRQ, 1'b0);
        INT_ENABLE <= 1'b1;
        rd_clr();
        cmp_bit(IRQ, 1'b0);
    endtask : t_basic
    task automatic t_collision;
        wr(8'h11);
        wr(8'h22);
        wr(8'h33);
        tick(2);
        cmp_bit(WRITE_COLLISION_FLAG, 1'b1);
        xfern(8'h01, 8, 1'b1);
        cmp_byte(rx, 8'h11);
        rd_clr();
        xfern(8'h02, 8, 1'b1);
        cmp_byte(rx, 8'h22);
        cmp_bit(RECEIVE_OVERRUN_FLAG, 1'b0);
        rd_clr();
    endtask : t_collision
    task automatic t_overrun;
        xfern(8'h5A, 8, 1'b1);
        @(posedge CLK);
        CLR_TRANSFER_DONE <= 1'b1;
        @(posedge CLK);
        CLR_TRANSFER_DONE <= 1'b0;
        xfern(8'hC3, 8, 1'b1);
        cmp_bit(RECEIVE_OVERRUN_FLAG, 1'b1);
        cmp_byte(DATA_RDATA, 8'h5A);
        CE <= 1'b0;
        rd_clr();
        cmp_bit(RECEIVE_OVERRUN_FLAG, 1'b1);
        CE <= 1'b1;
        rd_clr();
        cmp_byte(DATA_RDATA, 8'h5A);
    endtask : t_overrun
    task automatic t_polarity;
        sspf_master_model_inst.set_pol(1'b1);
        @(posedge CLK);
        CLK_POLARITY <= 1'b1;
        tick(4);
        wr(8'hC5);
        xfern(8'h5C, 8, 1'b1);
        cmp_byte(rx, 8'hC5);
        cmp_byte(DATA_RDATA, 8'h5C);
        rd_clr();
        sspf_master_model_inst.set_pol(1'b0);
        @(posedge CLK);
        CLK_POLARITY <= 1'b0;
        tick(4);
    endtask : t_polarity
    task automatic t_partial_4w;
        sspf_master_model_inst.xfer(8'hFF, 3, 1'b1, rx);
        tick(4);
        cmp_bit(TRANSFER_DONE_FLAG, 1'b0);
        xfern(8'h96, 8, 1'b1);
        cmp_byte(DATA_RDATA, 8'h96);
        rd_clr();
    endtask : t_partial_4w
    task automatic t_three_wire;
        cfg(sspf_pkg::SSPF_MODE_3W, 1'b1, 1'b0);
        sspf_master_model_inst.xfer(8'hA0, 3, 1'b1, rx);
        xfern(8'h98, 5, 1'b1);
        cmp_byte(DATA_RDATA, 8'hB3);
        rd_clr();
        sspf_master_model_inst.xfer(8'hFF, 3, 1'b0, rx);
        cfg(sspf_pkg::SSPF_MODE_3W, 1'b0, 1'b0);
        cfg(sspf_pkg::SSPF_MODE_3W, 1'b1, 1'b0);
        xfern(8'h69, 8, 1'b0);
        cmp_byte(DATA_RDATA, 8'h69);
        rd_clr();
    endtask : t_three_wire
    task automatic t_mode_fault;
        cfg(sspf_pkg::SSPF_MODE_4W, 1'b1, 1'b1);
        sspf_master_model_inst.xfer(8'h00, 0, 1'b1, rx);
        tick(2);
        cmp_bit(MODE_FAULT_FLAG, 1'b1);
        cmp_bit(FORCE_DISABLE, 1'b1);
        cfg(sspf_pkg::SSPF_MODE_4W, 1'b0, 1'b0);
        rd_clr();
    endtask : t_mode_fault
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {SRST, CE, CLK_PHASE, CLK_POLARITY, INT_ENABLE} = 5'h19;
        {PORT_ENABLE_BIT, MASTER_ENABLE_BIT, SELECT_MODE_BIT_HI, SELECT_MODE_BIT_LO} = 4'h9;
        {DATA_WR, DATA_RD, CLR_TRANSFER_DONE, CLR_WRITE_COLLISION} = 4'h0;
        {CLR_MODE_FAULT, CLR_RECEIVE_OVERRUN} = 2'h0;
        DATA_WDATA = 8'h00;
        tick(4);
        SRST <= 1'b0;
        tick(4);
        t_basic();
        t_collision();
        t_overrun();
        t_partial_4w();
        t_polarity();
        t_three_wire();
        t_mode_fault();
        stop_test();
    end
endmodule : sspf_top_bench

/* verilog/sspf_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sspf_buf2 import sspf_pkg::*; #(
    parameter int W = 8
) (
    input  wire logic clk,
    input  wire logic ce,
    input  wire logic srst,
    sspf_if.snk       in_p,
    output logic      out_valid,
    input  wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_ff [2];
    logic         wp_ff;
    logic         rp_ff;
    logic [1:0]   cnt_ff;
    logic         push;
    logic         pop;
    assign in_p.ready = (cnt_ff != 2'h2);
    assign push       = in_p.valid && in_p.ready;
    assign pop        = out_valid && out_ready;
    assign out_valid  = (cnt_ff != 2'h0);
    assign out_data   = mem_ff[rp_ff];
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (ce) begin
            if (push) begin
                mem_ff[wp_ff] <= in_p.data;
                wp_ff <= ~wp_ff;
            end
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sspf_buf2

/* verilog/sspf_if.sv */
// Byte stream carrier between the shifter and the receive buffer
`timescale 1ns/10ps
interface sspf_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sspf_if

/* verilog/sspf_pkg.sv */
// Constants and types for the serial slave port
//
// Contract
// RL1 - Enabled and not master: act as slave, master drives clock, data in and out.
// RL2 - Count clock edges; after 8 bits set done flag, copy byte to receive buffer.
// RL3 - Data register read returns the receive buffer.
// RL4 - Slave never starts a transfer itself.
// RL5 - Data write goes to transmit buffer, moves to empty shifter at once.
// RL6 - Busy shifter loads transmit buffer only after last clock edge of transfer.
// RL7 - Select mode bits 0,1 give default 4-wire mode using select input.
// RL8 - In 4-wire mode port active while select low, inactive while high.
// RL9 - In 4-wire mode a falling select edge clears the bit counter.
// RL10 - Master drives select low at least 2 clocks before first clock edge.
// RL11 - Select mode bits 0,0 give 3-wire mode, select ignored.
// RL12 - In 3-wire mode this device is the only slave on the bus.
// RL13 - In 3-wire mode only disable then enable resets the bit counter.
// RL14 - With interrupts enabled, any of four flags set raises the request.
// RL15 - Hardware never clears the four flags; software clears them.
// RL16 - Done flag set at end of every byte transfer in every mode.
// RL17 - Write while transmit buffer full sets collision flag and drops the write.
// RL18 - Master in multi-master mode with select low: fault, clear master and enable; code raises FORCE_DISABLE instead, held until software drops both.
// RL19 - Slave transfer done with unread buffer: overrun flag, keep old byte.
// RL20 - Data register read marks receive buffer as read.
package sspf_pkg;
    localparam int          SSPF_BITS      = 8;
    localparam logic [3:0]  SSPF_CNT_RST   = 4'h0;
    localparam logic [7:0]  SSPF_BYTE_RST  = 8'h00;
    localparam logic [1:0]  SSPF_MODE_3W   = 2'h0;
    localparam logic [1:0]  SSPF_MODE_4W   = 2'h1;
    localparam logic [1:0]  SSPF_MODE_MM   = 2'h1;
    localparam int          SSPF_NSS_SETUP = 2;
    typedef enum logic [1:0] {
        SSPF_IDLE = 2'b00,
        SSPF_SHIFT = 2'b01
    } sspf_state_e;
endpackage : sspf_pkg

/* verilog/sspf_sync.sv */
// Two flip-flop synchroniser
`timescale 1ns/10ps
module sspf_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         ce,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff <= RST;
            q     <= RST;
        end else if (ce) begin
            s1_ff <= d;
            q     <= s1_ff;
        end
    end
endmodule : sspf_sync

/* verilog/sspf_top.sv */
// Serial slave port with double buffering and four flags
`timescale 1ns/10ps
module sspf_top import sspf_pkg::*; (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    input  wire logic       SCK,
    input  wire logic       MOSI,
    input  wire logic       SLAVE_SELECT_IN,
    output logic            MISO,
    output logic            MISO_OE,
    input  wire logic       PORT_ENABLE_BIT,
    input  wire logic       MASTER_ENABLE_BIT,
    input  wire logic       SELECT_MODE_BIT_HI,
    input  wire logic       SELECT_MODE_BIT_LO,
    input  wire logic       CLK_PHASE,
    input  wire logic       CLK_POLARITY,
    input  wire logic       INT_ENABLE,
    input  wire logic       DATA_WR,
    input  wire logic [7:0] DATA_WDATA,
    input  wire logic       DATA_RD,
    output logic      [7:0] DATA_RDATA,
    input  wire logic       CLR_TRANSFER_DONE,
    input  wire logic       CLR_WRITE_COLLISION,
    input  wire logic       CLR_MODE_FAULT,
    input  wire logic       CLR_RECEIVE_OVERRUN,
    output logic            TRANSFER_DONE_FLAG,
    output logic            WRITE_COLLISION_FLAG,
    output logic            MODE_FAULT_FLAG,
    output logic            RECEIVE_OVERRUN_FLAG,
    output logic            FORCE_DISABLE,
    output logic            IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pins_s;
    logic       sck_s;
    logic       mosi_s;
    logic       nss_s;
    logic       sck_d_ff;
    logic       nss_d_ff;
    logic       en_d_ff;
    // Select resets to its idle high level, so no false select edge follows reset
    sspf_sync #(.W(3), .RST(3'h1)) u_sync (
        .clk  (CLK),
        .ce   (CE),
        .srst (SRST),
        .d    ({SCK, MOSI, SLAVE_SELECT_IN}),
        .q    (pins_s)
    );
    assign sck_s  = pins_s[2];
    assign mosi_s = pins_s[1];
    assign nss_s  = pins_s[0];
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sck_d_ff <= 1'b0;
            nss_d_ff <= 1'b1;
            en_d_ff  <= 1'b0;
        end else if (CE) begin
            sck_d_ff <= sck_s;
            nss_d_ff <= nss_s;
            en_d_ff  <= PORT_ENABLE_BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic [1:0] sel_mode;
    logic       mode_4w;
    logic       mode_3w;
    logic       slave_on;
    logic       active;
    logic       sck_rise;
    logic       sck_fall;
    logic       samp_edge;
    logic       shift_edge;
    logic       nss_fall;
    logic       en_rise;
    assign sel_mode = {SELECT_MODE_BIT_HI, SELECT_MODE_BIT_LO};
    assign mode_4w  = (sel_mode == SSPF_MODE_4W); // [RL7]
    assign mode_3w  = (sel_mode == SSPF_MODE_3W); // [RL11]
    assign slave_on = PORT_ENABLE_BIT && !MASTER_ENABLE_BIT && !FORCE_DISABLE; // [RL1]
    assign active   = slave_on && (mode_3w || (mode_4w && !nss_s)); // [RL8] [RL11]
    assign sck_rise = sck_s && !sck_d_ff;
    assign sck_fall = !sck_s && sck_d_ff;
    // Sample on leading or trailing edge per phase, polarity swaps the pair
    assign samp_edge  = (CLK_PHASE ^ CLK_POLARITY) ? sck_fall : sck_rise;
    assign shift_edge = (CLK_PHASE ^ CLK_POLARITY) ? sck_rise : sck_fall;
    assign nss_fall = !nss_s && nss_d_ff;
    assign en_rise  = PORT_ENABLE_BIT && !en_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and shifter
    sspf_state_e state_ff;
    logic [3:0]  cnt_ff;
    logic [7:0]  sh_ff;
    logic        sh_full_ff;
    logic [7:0]  txb_ff;
    logic        txb_full_ff;
    logic        last_bit;
    logic        done;
    logic        cnt_clr;
    sspf_if      rx_if ();
    assign cnt_clr  = (mode_4w && nss_fall) || en_rise || !PORT_ENABLE_BIT; // [RL9] [RL13]
    assign last_bit = active && samp_edge && (cnt_ff == 4'(SSPF_BITS - 1));
    assign done     = last_bit; // [RL2] [RL16]
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_ff   <= SSPF_CNT_RST;
            state_ff <= SSPF_IDLE;
        end else if (CE) begin
            if (cnt_clr) begin
                cnt_ff   <= SSPF_CNT_RST;
                state_ff <= SSPF_IDLE;
            end else if (active && samp_edge) begin // [RL4]
                if (last_bit) begin
                    cnt_ff   <= SSPF_CNT_RST;
                    state_ff <= SSPF_IDLE;
                end else begin
                    cnt_ff   <= cnt_ff + 4'h1;
                    state_ff <= SSPF_SHIFT;
                end
            end
        end
    end

    // Shift register and transmit buffer
    logic wr_ok;
    logic load_now;
    assign wr_ok    = DATA_WR && !txb_full_ff;
    // Empty and idle shifter loads at once; a running byte is never overwritten
    assign load_now = (!sh_full_ff && (state_ff == SSPF_IDLE) && !(active && samp_edge))
                      || last_bit; // [RL5] [RL6]
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sh_ff       <= SSPF_BYTE_RST;
            sh_full_ff  <= 1'b0;
            txb_ff      <= SSPF_BYTE_RST;
            txb_full_ff <= 1'b0;
        end else if (CE) begin
            if (wr_ok) begin
                txb_ff      <= DATA_WDATA; // [RL5]
                txb_full_ff <= 1'b1;
            end
            if (active && samp_edge) begin
                sh_ff <= {sh_ff[6:0], mosi_s};
            end
            if (last_bit) begin
                sh_full_ff <= 1'b0;
            end
            if (txb_full_ff && load_now) begin
                sh_ff       <= txb_ff; // [RL6]
                sh_full_ff  <= 1'b1;
                txb_full_ff <= wr_ok;
                if (wr_ok) begin
                    txb_ff <= DATA_WDATA;
                end
            end
        end
    end
    assign rx_if.data  = {sh_ff[6:0], mosi_s};

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer
    logic       rb_valid;
    logic [7:0] rb_data;
    logic       rb_unread_ff;
    logic       rb_pop;
    logic       overrun;
    sspf_buf2 #(.W(8)) u_rxbuf (
        .clk       (CLK),
        .ce        (CE),
        .srst      (SRST),
        .in_p      (rx_if),
        .out_valid (rb_valid),
        .out_ready (rb_pop),
        .out_data  (rb_data)
    );
    // Overrun keeps the old byte: new byte is not pushed past an unread one
    assign overrun = last_bit && (rb_unread_ff || !rx_if.ready); // [RL19]
    assign rx_if.valid = last_bit && !overrun; // [RL19]
    // Buffer holds one visible byte; next entry staged only if unread is clear
    assign rb_pop  = rb_valid && !rb_unread_ff;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rb_unread_ff <= 1'b0;
            DATA_RDATA   <= SSPF_BYTE_RST;
        end else if (CE) begin
            if (rb_pop) begin
                DATA_RDATA   <= rb_data; // [RL2]
                rb_unread_ff <= 1'b1;
            end else if (DATA_RD) begin
                rb_unread_ff <= 1'b0; // [RL3] [RL20]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, set wins over clear
    logic mfault;
    assign mfault = PORT_ENABLE_BIT && MASTER_ENABLE_BIT && (sel_mode == SSPF_MODE_MM)
                    && SELECT_MODE_BIT_LO && !SELECT_MODE_BIT_HI && !nss_s;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TRANSFER_DONE_FLAG   <= 1'b0;
            WRITE_COLLISION_FLAG <= 1'b0;
            MODE_FAULT_FLAG      <= 1'b0;
            RECEIVE_OVERRUN_FLAG <= 1'b0;
            FORCE_DISABLE        <= 1'b0;
            IRQ                  <= 1'b0;
        end else if (CE) begin
            TRANSFER_DONE_FLAG   <= done
                || (TRANSFER_DONE_FLAG && !CLR_TRANSFER_DONE); // [RL16] [RL15]
            WRITE_COLLISION_FLAG <= (DATA_WR && txb_full_ff)
                || (WRITE_COLLISION_FLAG && !CLR_WRITE_COLLISION); // [RL17] [RL15]
            MODE_FAULT_FLAG      <= mfault
                || (MODE_FAULT_FLAG && !CLR_MODE_FAULT); // [RL18] [RL15]
            RECEIVE_OVERRUN_FLAG <= (overrun && slave_on)
                || (RECEIVE_OVERRUN_FLAG && !CLR_RECEIVE_OVERRUN); // [RL19] [RL15]
            // Held until software drops both enables
            FORCE_DISABLE <= mfault || (FORCE_DISABLE
                             && (PORT_ENABLE_BIT || MASTER_ENABLE_BIT)); // [RL18]
            IRQ <= INT_ENABLE && (TRANSFER_DONE_FLAG || WRITE_COLLISION_FLAG
                   || MODE_FAULT_FLAG || RECEIVE_OVERRUN_FLAG); // [RL14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data out pin
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MISO    <= 1'b0;
            MISO_OE <= 1'b0;
        end else if (CE) begin
            MISO_OE <= active && mode_4w ? 1'b1 : active; // [RL8]
            if (!active || state_ff == SSPF_IDLE || shift_edge) begin
                MISO <= sh_ff[7];
            end
        end
    end
endmodule : sspf_top
